/* design/bcr_pkg.sv */
// Purpose: Shared constants and types for the bridge id/status registers
// Assumes: 32-bit APB register access, one aligned word per register
// Notes: Offsets of words after the identification word are local choice
package bcr_pkg;

   // ****************************************************************
   // Register offsets (byte addresses)
   // ****************************************************************
   localparam logic [11:0] OFS_ID = 12'h000;
   localparam logic [11:0] OFS_CSR = 12'h004;
   localparam logic [11:0] OFS_IRQ_STAT = 12'h008;
   localparam logic [11:0] OFS_IRQ_MASK = 12'h00c;

   // ****************************************************************
   // Command/status word field positions
   // ****************************************************************
   localparam int POS_DPE = 31;
   localparam int POS_SSERR = 30;
   localparam int POS_RMA = 29;
   localparam int POS_RTA = 28;
   localparam int POS_STA = 27;
   localparam int POS_MDP = 24;
   localparam int POS_CAP_LIST = 20;
   localparam int POS_SYS_ERR_EN = 8;
   localparam int POS_PAR_RESP = 6;

   // ****************************************************************
   // Flag vector layout, shared by interrupt status and mask
   // ****************************************************************
   localparam int NUM_FLAGS = 6;
   localparam int FLG_DPE = 5;
   localparam int FLG_SSERR = 4;
   localparam int FLG_RMA = 3;
   localparam int FLG_RTA = 2;
   localparam int FLG_STA = 1;
   localparam int FLG_MDP = 0;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [31:0] CSR_RESET = 32'h0010_0000;
   localparam logic [5:0] FLAGS_RESET = 6'h00;
   localparam logic [5:0] IRQ_MASK_RESET = 6'h00;
   localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

   // Link events, one-cycle pulses
   typedef struct packed {
      logic poisoned_rx;
      logic bad_ecrc_rx;
      logic err_msg_tx;
      logic cpl_ur_rx;
      logic cpl_ca_rx;
      logic ca_cpl_tx;
      logic poisoned_cpl_rx;
      logic poisoned_wr_tx;
   } bcr_event_t;

   // Identification word halves
   typedef struct packed {
      logic [15:0] device;
      logic [15:0] vendor;
   } bcr_ident_t;

   // APB slave states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_ACCESS = 2'b10
   } bcr_state_t;

endpackage

/* design/bcr_regs.sv */
// Purpose: Identification and command/status words with W1C error flags
// Assumes: Events and EEPROM load come from logic on clock_i
// Notes: One wait-free access phase per APB transfer
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// R01 - Upper identification half is device code, loadable
// R02 - Lower identification half is vendor code, loadable
// R03 - Poisoned or bad ECRC TLP sets bit 31
// R04 - Error message sent with report enable sets 30
// R05 - Unsupported Request completion received sets bit 29
// R06 - Completer Abort completion received sets bit 28
// R07 - Sending Completer Abort completion sets bit 27
// R08 - Parity enable plus poisoned completion/write sets 24
// R09 - Bit 24 never set while parity enable clear
// R10 - Select timing bits 26:25 read zero
// R11 - Bits 23, 22, 21 read zero
// R12 - Capability list bit 20 reads one
// R13 - Interrupt status bit 19 reads zero
// R14 - Parity response enable bit 6, RW, reset 0
// R15 - System error report enable bit 8, RW, reset 0
// R16 - Zero written keeps flag; read-only writes ignored
// R17 - Set beats a coinciding clearing write
module bcr_regs #(
   parameter logic [15:0] DEVICE_ID_DEFAULT = 16'h5a01, // Arbitrary value
   parameter logic [15:0] VENDOR_ID_DEFAULT = 16'h3c02  // Arbitrary value
) (
   input wire logic clock_i,
   input wire logic srst_i,
   input wire logic ce_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire bcr_pkg::bcr_event_t event_i,
   input wire logic ee_load_i,
   input wire bcr_pkg::bcr_ident_t ee_ident_i,
   output logic parity_response_enable_o,
   output logic system_error_report_enable_o,
   output logic irq_o
);

   // ****************************************************************
   // State
   // ****************************************************************
   bcr_pkg::bcr_state_t state_r;
   bcr_pkg::bcr_state_t state_nxt;
   bcr_pkg::bcr_ident_t ident_r;
   logic [5:0] flags_r;
   logic [5:0] flags_nxt;
   logic [5:0] irq_stat_r;
   logic [5:0] irq_stat_nxt;
   logic [5:0] irq_mask_r;
   logic parity_response_enable_r;
   logic system_error_report_enable_r;
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   logic irq_r;

   // ****************************************************************
   // Address decode and strobes
   // ****************************************************************
   wire logic setup_w = psel_i & ~penable_i & (state_r == bcr_pkg::ST_IDLE);
   wire logic commit_w = psel_i & penable_i & pready_r &
      (state_r == bcr_pkg::ST_ACCESS);
   wire logic wr_w = commit_w & pwrite_i;
   wire logic hit_id_w = (paddr_i == bcr_pkg::OFS_ID);
   wire logic hit_csr_w = (paddr_i == bcr_pkg::OFS_CSR);
   wire logic hit_stat_w = (paddr_i == bcr_pkg::OFS_IRQ_STAT);
   wire logic hit_mask_w = (paddr_i == bcr_pkg::OFS_IRQ_MASK);
   wire logic hit_w = hit_id_w | hit_csr_w | hit_stat_w | hit_mask_w;
   wire logic wr_csr_w = wr_w & hit_csr_w;
   wire logic wr_stat_w = wr_w & hit_stat_w;
   wire logic wr_mask_w = wr_w & hit_mask_w;

   // ****************************************************************
   // Flag set conditions
   // ****************************************************************
   wire logic [5:0] set_w;
   assign set_w[bcr_pkg::FLG_DPE] = event_i.poisoned_rx |
      event_i.bad_ecrc_rx | event_i.poisoned_cpl_rx; // R03
   assign set_w[bcr_pkg::FLG_SSERR] = event_i.err_msg_tx &
      system_error_report_enable_r; // R04
   assign set_w[bcr_pkg::FLG_RMA] = event_i.cpl_ur_rx; // R05
   assign set_w[bcr_pkg::FLG_RTA] = event_i.cpl_ca_rx; // R06
   assign set_w[bcr_pkg::FLG_STA] = event_i.ca_cpl_tx; // R07
   assign set_w[bcr_pkg::FLG_MDP] = parity_response_enable_r &
      (event_i.poisoned_cpl_rx | event_i.poisoned_wr_tx); // R08 R09

   // Clearing write bits gathered into flag layout
   wire logic [5:0] csr_clr_w = {6{wr_csr_w}} & {
      pwdata_i[bcr_pkg::POS_DPE], pwdata_i[bcr_pkg::POS_SSERR],
      pwdata_i[bcr_pkg::POS_RMA], pwdata_i[bcr_pkg::POS_RTA],
      pwdata_i[bcr_pkg::POS_STA], pwdata_i[bcr_pkg::POS_MDP]};
   wire logic [5:0] stat_clr_w = {6{wr_stat_w}} & pwdata_i[5:0];

   // Set wins over clear, zero bits keep their flag
   assign flags_nxt = (flags_r & ~csr_clr_w) | set_w; // R16 R17
   assign irq_stat_nxt = (irq_stat_r & ~stat_clr_w) | set_w; // R17
   // New mask takes effect on the interrupt line at once
   wire logic [5:0] irq_mask_nxt = wr_mask_w ? pwdata_i[5:0] : irq_mask_r;
   wire logic irq_nxt = |(irq_stat_nxt & irq_mask_nxt);

   // ****************************************************************
   // Read data assembly
   // ****************************************************************
   wire logic [31:0] csr_word_w = {
      flags_r[bcr_pkg::FLG_DPE], flags_r[bcr_pkg::FLG_SSERR],
      flags_r[bcr_pkg::FLG_RMA], flags_r[bcr_pkg::FLG_RTA],
      flags_r[bcr_pkg::FLG_STA],
      2'b00,           // R10
      flags_r[bcr_pkg::FLG_MDP],
      3'b000,          // R11
      1'b1,            // R12
      1'b0,            // R13
      10'h000,
      system_error_report_enable_r,
      1'b0,
      parity_response_enable_r,
      6'h00};
   wire logic [31:0] rd_mux_w =
      hit_id_w ? ident_r :
      hit_csr_w ? csr_word_w :
      hit_stat_w ? {26'h0000000, irq_stat_r} :
      hit_mask_w ? {26'h0000000, irq_mask_r} : 32'h0000_0000;

   // APB state transition
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         bcr_pkg::ST_IDLE: begin
            if (setup_w) begin
               state_nxt = bcr_pkg::ST_ACCESS;
            end
         end
         bcr_pkg::ST_ACCESS: begin
            state_nxt = bcr_pkg::ST_IDLE;
         end
         default: begin
            state_nxt = bcr_pkg::ST_IDLE;
         end
      endcase
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   // APB handshake and read data
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         state_r <= bcr_pkg::ST_IDLE;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= bcr_pkg::RDATA_RESET;
      end else if (ce_i) begin
         state_r <= state_nxt;
         pready_r <= setup_w;
         pslverr_r <= setup_w & ~hit_w;
         prdata_r <= (setup_w & ~pwrite_i) ? rd_mux_w : prdata_r;
      end
   end

   // Identification word, EEPROM override
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         ident_r <= {DEVICE_ID_DEFAULT, VENDOR_ID_DEFAULT};
      end else if (ce_i && ee_load_i) begin
         ident_r <= ee_ident_i; // R01 R02
      end
   end

   // Command enables
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         parity_response_enable_r <=
            bcr_pkg::CSR_RESET[bcr_pkg::POS_PAR_RESP];
         system_error_report_enable_r <=
            bcr_pkg::CSR_RESET[bcr_pkg::POS_SYS_ERR_EN];
      end else if (ce_i && wr_csr_w) begin
         parity_response_enable_r <= pwdata_i[bcr_pkg::POS_PAR_RESP]; // R14
         system_error_report_enable_r <=
            pwdata_i[bcr_pkg::POS_SYS_ERR_EN]; // R15
      end
   end

   // Status flags, interrupt status, mask and line
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         flags_r <= bcr_pkg::FLAGS_RESET;
         irq_stat_r <= bcr_pkg::FLAGS_RESET;
         irq_mask_r <= bcr_pkg::IRQ_MASK_RESET;
         irq_r <= 1'b0;
      end else if (ce_i) begin
         flags_r <= flags_nxt;
         irq_stat_r <= irq_stat_nxt;
         irq_mask_r <= irq_mask_nxt;
         irq_r <= irq_nxt;
      end
   end

   // Outputs straight from flops
   assign prdata_o = prdata_r;
   assign pready_o = pready_r;
   assign pslverr_o = pslverr_r;
   assign parity_response_enable_o = parity_response_enable_r;
   assign system_error_report_enable_o = system_error_report_enable_r;
   assign irq_o = irq_r;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (srst_i || !ce_i);

   // Identification load
   chk_ident_upper: assert property ( // R01
      ee_load_i |=> ident_r.device == $past(ee_ident_i.device))
      else $error("device code not loaded");
   chk_ident_lower: assert property ( // R02
      ee_load_i |=> ident_r.vendor == $past(ee_ident_i.vendor))
      else $error("vendor code not loaded");

   // Flag setting
   chk_dpe_set: assert property ( // R03
      (event_i.poisoned_rx || event_i.bad_ecrc_rx)
      |=> csr_word_w[bcr_pkg::POS_DPE])
      else $error("detected parity flag not set");
   chk_sserr_set: assert property ( // R04
      $rose(flags_r[bcr_pkg::FLG_SSERR])
      |-> $past(event_i.err_msg_tx && system_error_report_enable_r))
      else $error("system error flag set without cause");
   chk_rma_set: assert property ( // R05
      event_i.cpl_ur_rx |=> csr_word_w[bcr_pkg::POS_RMA])
      else $error("master abort flag not set");
   chk_rta_set: assert property ( // R06
      event_i.cpl_ca_rx |=> csr_word_w[bcr_pkg::POS_RTA])
      else $error("target abort flag not set");
   chk_sta_set: assert property ( // R07
      event_i.ca_cpl_tx |=> csr_word_w[bcr_pkg::POS_STA])
      else $error("signaled abort flag not set");
   chk_mdp_set: assert property ( // R08
      parity_response_enable_r && event_i.poisoned_wr_tx
      |=> csr_word_w[bcr_pkg::POS_MDP])
      else $error("master parity flag not set");
   chk_mdp_never: assert property ( // R09
      $rose(flags_r[bcr_pkg::FLG_MDP]) |-> $past(parity_response_enable_r))
      else $error("master parity flag set while disabled");

   // Fixed bits in read answer
   chk_fixed_bits: assert property ( // R10 R11 R12 R13
      pready_r && !pwrite_i && hit_csr_w
      |-> {prdata_r[26:25], prdata_r[23:19]} == 7'h02)
      else $error("fixed status bits wrong");

   // Enables follow written value
   chk_enable_wr: assert property ( // R14 R15
      wr_csr_w |=> parity_response_enable_o ==
      $past(pwdata_i[bcr_pkg::POS_PAR_RESP]) && system_error_report_enable_o
      == $past(pwdata_i[bcr_pkg::POS_SYS_ERR_EN]))
      else $error("command enable not written");

   // Zero write keeps flag, set beats clear
   chk_zero_keeps: assert property ( // R16
      wr_csr_w && !pwdata_i[bcr_pkg::POS_RMA] && flags_r[bcr_pkg::FLG_RMA]
      |=> flags_r[bcr_pkg::FLG_RMA])
      else $error("flag lost on zero write");
   chk_set_wins: assert property ( // R17
      wr_csr_w && pwdata_i[bcr_pkg::POS_RMA] && event_i.cpl_ur_rx
      |=> flags_r[bcr_pkg::FLG_RMA] [*2])
      else $error("clear beat coinciding set");

   // Interrupt line
   chk_irq_line: assert property (
      irq_o == |(irq_stat_r & irq_mask_r))
      else $error("interrupt line mismatch");

   // Poisoned completion path of the parity flag
   chk_mdp_cpl: assert property ( // R08
      parity_response_enable_r && event_i.poisoned_cpl_rx
      |=> csr_word_w[bcr_pkg::POS_MDP])
      else $error("master parity flag not set by completion");

   // Identification word ignores bus writes
   chk_ident_ro: assert property ( // R16
      wr_w && hit_id_w && !ee_load_i |=> ident_r == $past(ident_r))
      else $error("identification word changed by write");

   // Handshake answer shape
   chk_pready_pulse: assert property (
      pready_o |=> !pready_o)
      else $error("ready held longer than one cycle");
   chk_unmapped_rd: assert property (
      setup_w && !hit_w && !pwrite_i
      |=> pslverr_o && prdata_o == 32'h0000_0000)
      else $error("unmapped read not refused");

   // Main scenarios
   cov_read_csr: cover property (commit_w && !pwrite_i && hit_csr_w);
   cov_clear_flag: cover property (
      flags_r[bcr_pkg::FLG_DPE] ##1 wr_csr_w ##1 !flags_r[bcr_pkg::FLG_DPE]);
   cov_irq_raise: cover property ($rose(irq_o));
   cov_ee_load: cover property (ee_load_i ##1 ident_r != $past(ident_r));
   cov_race_set: cover property (wr_csr_w && event_i.cpl_ur_rx);

endmodule
`default_nettype wire

/* testbench/bcr_link_model.sv */
// Purpose: Link-side event and EEPROM source facing the register block
// Assumes: Called from the bench, all changes just after a rising edge
// Notes: Pulses last one cycle; ident lines do not hold after the load
`timescale 1ns/1ps
`default_nettype none
module bcr_link_model (
   input wire logic clock_i,
   output var bcr_pkg::bcr_event_t event_o,
   output var logic ee_load_o,
   output var bcr_pkg::bcr_ident_t ee_ident_o
);
   // Idle levels at time zero
   initial begin
      event_o = '0;
      ee_load_o = 1'b0;
      ee_ident_o = '0;
   end

   // One-cycle link event pulse
   task automatic pulse(input bcr_pkg::bcr_event_t ev);
      event_o <= ev;
      @(posedge clock_i);
      event_o <= '0;
   endtask

   // One-cycle EEPROM load; ident lines turn over afterwards
   task automatic load(input bcr_pkg::bcr_ident_t id);
      ee_ident_o <= id;
      ee_load_o <= 1'b1;
      @(posedge clock_i);
      ee_load_o <= 1'b0;
      ee_ident_o <= ~id;
   endtask
endmodule
`default_nettype wire

/* testbench/bcr_regs_bench.sv */
// Purpose: Self-checking bench for the id and command/status registers
// Assumes: APB master tasks, link events from the partner model
// Notes: Expected values are worked out from the register layout
`timescale 1ns/1ps
`default_nettype none
module bcr_regs_bench;
   localparam logic [15:0] DEV_ID = 16'h7e21; // Arbitrary value
   localparam logic [15:0] VEN_ID = 16'h4b13; // Arbitrary value
   localparam logic [31:0] BASE = 32'h0010_0000;
   logic clock_i, srst_i, psel, penable, pwrite, pready, pslverr, irq;
   logic pe_en, se_en, ee_load, err, ce;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, enb, f;
   bcr_pkg::bcr_event_t ev;
   bcr_pkg::bcr_ident_t ee_id;
   int n_mismatch = 0;
   int samples_checked = 0;

   // ****************************************************************
   // Design and partner
   // ****************************************************************
   bcr_regs #(.DEVICE_ID_DEFAULT(DEV_ID), .VENDOR_ID_DEFAULT(VEN_ID))
   u_bcr_regs (
      .clock_i(clock_i), .srst_i(srst_i), .ce_i(ce), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .event_i(ev), .ee_load_i(ee_load),
      .ee_ident_i(ee_id), .parity_response_enable_o(pe_en),
      .system_error_report_enable_o(se_en), .irq_o(irq));
   bcr_link_model u_bcr_link_model (.clock_i(clock_i), .event_o(ev),
      .ee_load_o(ee_load), .ee_ident_o(ee_id));

   // 125 MHz clock
   initial begin
      clock_i = 1'b0;
      forever #4 clock_i = ~clock_i;
   end

   // ****************************************************************
   // Tasks and expectations
   // ****************************************************************
   task automatic final_report();
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic check(input string nm, input logic [31:0] exp,
      input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         $display("Error %s expected %h seen %h", nm, exp, got);
         n_mismatch++;
      end
   endtask

   // One APB transfer; an optional event lands on the commit edge
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] wd, input logic [7:0] evc, output logic e);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clock_i);
      penable <= 1'b1;
      if (evc != 8'h00) begin
         fork
            u_bcr_link_model.pulse(bcr_pkg::bcr_event_t'(evc));
         join_none
      end
      do begin
         @(posedge clock_i);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         $display("Error pready expected 1 seen %b", pready);
         n_mismatch++;
         final_report();
      end
      rd = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock_i);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic e;
      apb(1'b1, a, d, 8'h00, e);
   endtask

   task automatic chk_rd(input string nm, input logic [11:0] a,
      input logic [31:0] exp);
      logic e;
      apb(1'b0, a, 32'h0, 8'h00, e);
      check(nm, exp, rd);
   endtask

   // Flags set by event bit i with both enables at en
   function automatic logic [31:0] exp_flags(input int i, input logic en);
      case (i)
         7, 6: return 32'h8000_0000;
         5: return en ? 32'h4000_0000 : 32'h0;
         4: return 32'h2000_0000;
         3: return 32'h1000_0000;
         2: return 32'h0800_0000;
         1: return en ? 32'h8100_0000 : 32'h8000_0000;
         default: return en ? 32'h0100_0000 : 32'h0;
      endcase
   endfunction

   function automatic logic [5:0] irq_map(input logic [31:0] c);
      return {c[31], c[30], c[29], c[28], c[27], c[24]};
   endfunction

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      srst_i = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      ce = 1'b1;
      repeat (6) @(posedge clock_i);
      srst_i <= 1'b0;
      @(posedge clock_i);
      chk_rd("id", 12'h000, {DEV_ID, VEN_ID});
      chk_rd("csr", 12'h004, BASE);
      wr(12'h000, 32'h0);
      chk_rd("id_ro", 12'h000, {DEV_ID, VEN_ID});
      wr(12'h004, 32'h06ff_ffff);
      chk_rd("csr_ro", 12'h004, BASE | 32'h140);
      check("enables", 32'h3, {30'h0, se_en, pe_en});
      for (int en = 0; en < 2; en++) begin
         enb = en[0] ? 32'h0000_0140 : 32'h0;
         wr(12'h004, enb);
         wr(12'h00c, en[0] ? 32'h3f : 32'h0);
         for (int i = 0; i < 8; i++) begin
            f = BASE | enb | exp_flags(i, en[0]);
            u_bcr_link_model.pulse(bcr_pkg::bcr_event_t'(8'h01 << i));
            repeat (2) @(posedge clock_i);
            check("irq", {31'h0, en[0] & (|irq_map(f))}, {31'h0, irq});
            chk_rd("csr_ev", 12'h004, f);
            chk_rd("stat", 12'h008, {26'h0, irq_map(f)});
            wr(12'h004, enb);
            chk_rd("csr_w0", 12'h004, f);
            wr(12'h004, enb | 32'hf900_0000);
            wr(12'h008, 32'h3f);
            chk_rd("csr_clr", 12'h004, BASE | enb);
            chk_rd("stat_clr", 12'h008, 32'h0);
            check("irq_clr", 32'h0, {31'h0, irq});
         end
      end
      apb(1'b1, 12'h004, 32'h2000_0140, 8'h10, err);
      chk_rd("csr_race", 12'h004, BASE | 32'h2000_0140);
      // Event while the clock enable is low must be lost
      ce <= 1'b0;
      u_bcr_link_model.pulse(bcr_pkg::bcr_event_t'(8'h08));
      @(posedge clock_i);
      ce <= 1'b1;
      chk_rd("csr_frozen", 12'h004, BASE | 32'h2000_0140);
      apb(1'b0, 12'h010, 32'h0, 8'h00, err);
      check("slverr", 32'h1, {31'h0, err});
      check("rd_unmapped", 32'h0, rd);
      u_bcr_link_model.load({16'h1234, 16'h5678});
      @(posedge clock_i);
      chk_rd("id_ee", 12'h000, 32'h1234_5678);
      final_report();
   end
endmodule
`default_nettype wire
